// File: inc/p8t_pkg.sv
// Overview of operation
// - Prescaler steps once per twelve core-clock cycles, on the divided edge.
// - Prescaler at zero reloads with 7Fh and keeps counting.
// - Counter steps down once per edge of the selected prescaler tap.
// - Counter at zero reloads with 0FFh and keeps counting freely.
// - Select field 0 to 7 divides the counter clock by 1 to 128.
// - Run bit low holds counter and forces prescaler to 7Fh.
// - Reset puts 0FFh in the counter and 7Fh in the prescaler.
// - With run bit high, writing the prescaler register loads it directly.
// - Counter register is readable and writable while counting continues.
// - Counter wrap from 00h to FFh sets zero flag; enabled flag requests interrupt.
// - Writing 00h to counter or one to control bit 7 sets flag.
// - Zero flag stays set until software writes it to zero.
// - Counter write beats a same-cycle decrement; no flag from that decrement.
// - In WAIT the timer runs on and its interrupt wakes the processor.
// - In STOP all timer registers freeze, so no underflow can occur.
// - Prescaler register reads live value in bits 6:0, bit 7 zero.
// - Control register: flag bit 7, enable 6, run 3, select 2:0.
package p8t_pkg;

	// Core clock division feeding the prescaler
	localparam int unsigned P8T_DIV_RATIO = 12;
	localparam logic [3:0] P8T_DIV_LAST = 4'(P8T_DIV_RATIO - 1);
	localparam logic [3:0] P8T_DIV_ZERO = 4'h0;

	// Register addresses
	localparam logic [7:0] P8T_ADDR_PRESC = 8'hd2;
	localparam logic [7:0] P8T_ADDR_CNT = 8'hd3;
	localparam logic [7:0] P8T_ADDR_CTRL = 8'hd4;
	localparam logic [7:0] P8T_ADDR_EVT = 8'hd5;
	localparam logic [7:0] P8T_ADDR_MASK = 8'hd6;

	// Reload and reset values
	localparam logic [6:0] P8T_PRESC_RELOAD = 7'h7f;
	localparam logic [6:0] P8T_PRESC_ZERO = 7'h00;
	localparam logic [7:0] P8T_CNT_RELOAD = 8'hff;
	localparam logic [7:0] P8T_CNT_ZERO = 8'h00;
	localparam logic [7:0] P8T_CTRL_RESET = 8'h00;
	localparam logic [7:0] P8T_READ_IDLE = 8'h00;
	localparam int unsigned P8T_EVT_W = 2;
	localparam logic [P8T_EVT_W-1:0] P8T_EVT_NONE = 2'h0;
	localparam logic [6:0] P8T_MASK_ONE = 7'h01;

	// Register bus request, one cycle per access
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} p8t_bus_req_type;

	// Status/control layout, bit 7 down to bit 0
	typedef struct packed {
		logic zero_flag;
		logic zero_irq_enable;
		logic reserved_set_bit;
		logic reserved_clear_bit;
		logic prescaler_run;
		logic [2:0] prescale_select;
	} p8t_ctrl_type;

	// Sticky event bits
	typedef struct packed {
		logic presc_wrap;
		logic underflow;
	} p8t_evt_type;

	// Low prescaler bits that must be zero for a tap edge
	function automatic logic [6:0] p8t_tap_mask(input logic [2:0] sel);
		p8t_tap_mask = 7'((P8T_MASK_ONE << sel) - P8T_MASK_ONE);
	endfunction

endpackage

// File: logic/p8t_div12.sv
`timescale 1ns/1ps
module p8t_div12 (
	input wire logic clk_in, // Core clock
	input wire logic rstn_in, // Async reset, active low
	input wire logic en_in, // Count enable, low freezes
	output logic tick_out // One cycle per twelve clocks
);
	import p8t_pkg::*;

	logic [3:0] div_r;

	// Modulo-twelve cycle counter
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			div_r <= P8T_DIV_ZERO;
		end else if (en_in) begin
			div_r <= (div_r == P8T_DIV_LAST) ? P8T_DIV_ZERO : div_r + 4'h1;
		end
	end

	// Divided edge as enable pulse
	assign tick_out = en_in && (div_r == P8T_DIV_LAST);
endmodule

// File: logic/p8t_tap.sv
`timescale 1ns/1ps
module p8t_tap (
	input wire logic tick_in, // Prescaler step enable
	input wire logic [6:0] presc_in, // Prescaler value before step
	input wire logic [2:0] sel_in, // Tap select
	output logic tap_en_out // Counter step enable
);
	import p8t_pkg::*;

	// Tap bit n toggles when the low n bits borrow on this step
	assign tap_en_out = tick_in &&
		((presc_in & p8t_tap_mask(sel_in)) == P8T_PRESC_ZERO);
endmodule

// File: logic/p8t_timer.sv
`timescale 1ns/1ps
module p8t_timer (
	input wire logic CLK_IN, // Core clock, 20 MHz
	input wire logic RSTN_IN, // Async reset, active low
	input wire p8t_pkg::p8t_bus_req_type BUS_IN, // Register request
	output logic [7:0] RDATA_OUT, // Read data, cycle after read
	input wire logic WAIT_IN, // Core in WAIT
	input wire logic STOP_IN, // Core in STOP
	output logic IRQ_OUT, // Interrupt request level
	output logic WAKE_OUT // Wake request while in WAIT
);
	import p8t_pkg::*;

	localparam int TICK_GAP = P8T_DIV_RATIO;

	logic tick;
	logic presc_step;
	logic cnt_en;
	logic run;
	logic wr_presc;
	logic wr_cnt;
	logic wr_ctrl;
	logic wr_evt;
	logic wr_mask;
	logic underflow;
	logic presc_wrap;
	logic zf_set;
	logic [6:0] presc_r;
	logic [7:0] cnt_r;
	p8t_ctrl_type ctrl_r;
	p8t_ctrl_type ctrl_wr;
	p8t_evt_type evt_r;
	p8t_evt_type evt_set;
	p8t_evt_type evt_wr;
	p8t_evt_type mask_r;
	logic [7:0] rdata_r;
	logic [7:0] rd_mux;

	// Write decode; STOP blocks all register changes
	assign wr_presc = BUS_IN.wr && !STOP_IN &&
		(BUS_IN.addr == P8T_ADDR_PRESC);
	assign wr_cnt = BUS_IN.wr && !STOP_IN && (BUS_IN.addr == P8T_ADDR_CNT);
	assign wr_ctrl = BUS_IN.wr && !STOP_IN &&
		(BUS_IN.addr == P8T_ADDR_CTRL);
	assign wr_evt = BUS_IN.wr && !STOP_IN && (BUS_IN.addr == P8T_ADDR_EVT);
	assign wr_mask = BUS_IN.wr && !STOP_IN &&
		(BUS_IN.addr == P8T_ADDR_MASK);
	assign ctrl_wr = p8t_ctrl_type'(BUS_IN.wdata);
	assign evt_wr = p8t_evt_type'(BUS_IN.wdata[P8T_EVT_W-1:0]);
	assign run = ctrl_r.prescaler_run;

	// Divide-by-twelve time base, frozen in STOP
	p8t_div12 u_div (
		.clk_in(CLK_IN),
		.rstn_in(RSTN_IN),
		.en_in(!STOP_IN),
		.tick_out(tick)
	);

	// Prescaler steps only while running
	assign presc_step = tick && run;

	// Selected tap to counter enable pulse
	p8t_tap u_tap (
		.tick_in(presc_step),
		.presc_in(presc_r),
		.sel_in(ctrl_r.prescale_select),
		.tap_en_out(cnt_en)
	);

	// Prescaler: forced, loaded or stepped
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			presc_r <= P8T_PRESC_RELOAD;
		end else if (STOP_IN) begin
			presc_r <= presc_r;
		end else if (!run) begin
			presc_r <= P8T_PRESC_RELOAD;
		end else if (wr_presc) begin
			presc_r <= BUS_IN.wdata[6:0];
		end else if (presc_step) begin
			if (presc_r == P8T_PRESC_ZERO) begin
				presc_r <= P8T_PRESC_RELOAD;
			end else begin
				presc_r <= presc_r - 7'h01;
			end
		end
	end

	// Counter: software write wins over a step
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			cnt_r <= P8T_CNT_RELOAD;
		end else if (STOP_IN) begin
			cnt_r <= cnt_r;
		end else if (wr_cnt) begin
			cnt_r <= BUS_IN.wdata;
		end else if (cnt_en) begin
			if (cnt_r == P8T_CNT_ZERO) begin
				cnt_r <= P8T_CNT_RELOAD;
			end else begin
				cnt_r <= cnt_r - 8'h01;
			end
		end
	end

	// Events of this cycle
	assign underflow = cnt_en && !wr_cnt && (cnt_r == P8T_CNT_ZERO);
	assign presc_wrap = presc_step && !wr_presc &&
		(presc_r == P8T_PRESC_ZERO);
	assign zf_set = underflow ||
		(wr_cnt && (BUS_IN.wdata == P8T_CNT_ZERO)) ||
		(wr_ctrl && ctrl_wr.zero_flag);

	// Control register, one driver; flag set wins over a clear
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			ctrl_r <= p8t_ctrl_type'(P8T_CTRL_RESET);
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= ctrl_wr;
			end
			if (zf_set) begin
				ctrl_r.zero_flag <= 1'b1;
			end
		end
	end

	// Sticky event status, write one to clear, set wins
	assign evt_set.underflow = underflow;
	assign evt_set.presc_wrap = presc_wrap;
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			evt_r <= P8T_EVT_NONE;
		end else if (wr_evt) begin
			evt_r <= (evt_r & ~evt_wr) | evt_set;
		end else begin
			evt_r <= evt_r | evt_set;
		end
	end

	// Event mask
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			mask_r <= P8T_EVT_NONE;
		end else if (wr_mask) begin
			mask_r <= evt_wr;
		end
	end

	// Interrupt level and WAIT wake
	assign IRQ_OUT = (ctrl_r.zero_flag && ctrl_r.zero_irq_enable) ||
		(|(evt_r & mask_r));
	assign WAKE_OUT = WAIT_IN && IRQ_OUT;

	// Read multiplexer, unmapped reads zero
	always_comb begin
		rd_mux = P8T_READ_IDLE;
		unique case (BUS_IN.addr)
			P8T_ADDR_PRESC: rd_mux = {1'b0, presc_r};
			P8T_ADDR_CNT: rd_mux = cnt_r;
			P8T_ADDR_CTRL: rd_mux = ctrl_r;
			P8T_ADDR_EVT: rd_mux = {6'h00, evt_r};
			P8T_ADDR_MASK: rd_mux = {6'h00, mask_r};
			default: rd_mux = P8T_READ_IDLE;
		endcase
	end

	// Read data valid only the cycle after the strobe
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			rdata_r <= P8T_READ_IDLE;
		end else if (BUS_IN.rd) begin
			rdata_r <= rd_mux;
		end else begin
			rdata_r <= P8T_READ_IDLE;
		end
	end
	assign RDATA_OUT = rdata_r;

	// Time base spacing
	property p_tick_gap;
		@(posedge CLK_IN) disable iff (!RSTN_IN || STOP_IN)
		tick |=> (!tick)[*8] ##1 (!tick)[*3] ##1 tick;
	endproperty
	a_tick_gap: assert property (p_tick_gap)
		else $error("prescaler tick spacing is not twelve cycles");

	property p_tick_period;
		@(posedge CLK_IN) disable iff (!RSTN_IN || STOP_IN)
		tick |-> ##TICK_GAP tick;
	endproperty
	a_tick_period: assert property (p_tick_period)
		else $error("prescaler tick period wrong");

	// Prescaler step and reload
	sequence s_presc_step;
		presc_step && !wr_presc && !STOP_IN;
	endsequence
	property p_presc_dec;
		@(posedge CLK_IN) disable iff (!RSTN_IN)
		s_presc_step ##0 (presc_r != P8T_PRESC_ZERO) |=>
			(presc_r == $past(presc_r) - 7'h01);
	endproperty
	a_presc_dec: assert property (p_presc_dec)
		else $error("prescaler did not step down");

	property p_presc_reload;
		@(posedge CLK_IN) disable iff (!RSTN_IN)
		s_presc_step ##0 (presc_r == P8T_PRESC_ZERO) ##1 run |->
			(presc_r == P8T_PRESC_RELOAD);
	endproperty
	a_presc_reload: assert property (p_presc_reload)
		else $error("prescaler did not reload");

	// Counter step, underflow and flag
	sequence s_cnt_step;
		cnt_en && !wr_cnt && !STOP_IN;
	endsequence
	property p_cnt_dec;
		@(posedge CLK_IN) disable iff (!RSTN_IN)
		s_cnt_step ##0 (cnt_r != P8T_CNT_ZERO) |=>
			(cnt_r == $past(cnt_r) - 8'h01);
	endproperty
	a_cnt_dec: assert property (p_cnt_dec)
		else $error("counter did not step down");

	property p_underflow;
		@(posedge CLK_IN) disable iff (!RSTN_IN)
		s_cnt_step ##0 (cnt_r == P8T_CNT_ZERO) |=>
			(cnt_r == P8T_CNT_RELOAD) && ctrl_r.zero_flag;
	endproperty
	a_underflow: assert property (p_underflow)
		else $error("underflow did not reload or flag");

	// Tap division: counter steps only at tap edges
	property p_tap_edge;
		@(posedge CLK_IN) disable iff (!RSTN_IN)
		(presc_step || cnt_en) |-> presc_step && (cnt_en ==
			(((presc_r >> ctrl_r.prescale_select) <<
			ctrl_r.prescale_select) == presc_r));
	endproperty
	a_tap_edge: assert property (p_tap_edge)
		else $error("counter stepped off the tap edge");

	// Stopped prescaler stays at reload, counter holds
	property p_run_low;
		@(posedge CLK_IN) disable iff (!RSTN_IN)
		!run && !wr_cnt && !STOP_IN |=>
			(presc_r == P8T_PRESC_RELOAD) && $stable(cnt_r);
	endproperty
	a_run_low: assert property (p_run_low)
		else $error("timer moved while run bit low");

	// Write wins and leaves flag alone
	property p_write_wins;
		@(posedge CLK_IN) disable iff (!RSTN_IN)
		wr_cnt && cnt_en && (BUS_IN.wdata != P8T_CNT_ZERO) &&
			!ctrl_r.zero_flag && !wr_ctrl |=>
			(cnt_r == $past(BUS_IN.wdata)) && !ctrl_r.zero_flag;
	endproperty
	a_write_wins: assert property (p_write_wins)
		else $error("counter write lost to decrement");

	property p_zero_write;
		@(posedge CLK_IN) disable iff (!RSTN_IN)
		wr_cnt && (BUS_IN.wdata == P8T_CNT_ZERO) |=> ctrl_r.zero_flag;
	endproperty
	a_zero_write: assert property (p_zero_write)
		else $error("writing zero did not set flag");

	property p_flag_sticky;
		@(posedge CLK_IN) disable iff (!RSTN_IN)
		ctrl_r.zero_flag && !wr_ctrl |=> ctrl_r.zero_flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("zero flag dropped without a write");

	// STOP freezes everything
	property p_stop_freeze;
		@(posedge CLK_IN) disable iff (!RSTN_IN)
		STOP_IN |=> $stable(presc_r) && $stable(cnt_r) && $stable(ctrl_r);
	endproperty
	a_stop_freeze: assert property (p_stop_freeze)
		else $error("timer changed in STOP");

	// Live prescaler readback
	property p_presc_read;
		@(posedge CLK_IN) disable iff (!RSTN_IN)
		BUS_IN.rd && (BUS_IN.addr == P8T_ADDR_PRESC) |=>
			(RDATA_OUT == {1'b0, $past(presc_r)});
	endproperty
	a_presc_read: assert property (p_presc_read)
		else $error("prescaler readback wrong");

	property p_wake;
		@(posedge CLK_IN) disable iff (!RSTN_IN)
		WAIT_IN && ctrl_r.zero_flag && ctrl_r.zero_irq_enable |->
			WAKE_OUT;
	endproperty
	a_wake: assert property (p_wake)
		else $error("enabled zero flag did not wake from WAIT");
endmodule

// File: test/p8t_cpu_model.sv
`timescale 1ns/1ps
module p8t_cpu_model (
	input wire logic clk_in, // Core clock
	input wire logic [7:0] rdata_in, // Read data from timer
	output p8t_pkg::p8t_bus_req_type bus_out, // Register request
	output logic wait_out, // Core in WAIT
	output logic stop_out // Core in STOP
);
	import p8t_pkg::*;

	// Idle bus and running core at time zero
	initial begin
		bus_out = '0;
		wait_out = 1'b0;
		stop_out = 1'b0;
	end

	// One write cycle, released at the taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		bus_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_in);
		bus_out <= '0;
	endtask

	// One read cycle, data taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(posedge clk_in);
		bus_out <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_in);
		bus_out <= '0;
		@(negedge clk_in);
		q = rdata_in;
	endtask

	// Control write; reserved pair always written as one and zero
	task automatic ctrl(input logic f, input logic ie, input logic run,
		input logic [2:0] sel);
		wr(P8T_ADDR_CTRL, {f, ie, 2'b10, run, sel});
	endtask

	// Wait some edges, then set the power mode lines
	task automatic hold(input int n, input logic w, input logic s);
		repeat (n) @(posedge clk_in);
		wait_out <= w;
		stop_out <= s;
	endtask
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
	import p8t_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	p8t_bus_req_type bus;
	logic [7:0] rdata;
	logic wait_s;
	logic stop_s;
	logic irq;
	logic wake;
	int errors = 0;
	int compares = 0;
	int cyc = 0;
	logic [31:0] seed = 32'h5c0d;
	logic [7:0] rst_tab [6] = '{8'h7f, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};

	// Free-running core clock, 50 ns period
	always #25 clk = ~clk;

	// Edges since release; a tick edge leaves a multiple of twelve until STOP first freezes the time base
	always @(posedge clk) begin
		if (rstn) begin
			cyc <= cyc + 1;
		end
	end

	p8t_timer dut_u (
		.CLK_IN(clk),
		.RSTN_IN(rstn),
		.BUS_IN(bus),
		.RDATA_OUT(rdata),
		.WAIT_IN(wait_s),
		.STOP_IN(stop_s),
		.IRQ_OUT(irq),
		.WAKE_OUT(wake)
	);

	p8t_cpu_model cpu_u (
		.clk_in(clk),
		.rdata_in(rdata),
		.bus_out(bus),
		.wait_out(wait_s),
		.stop_out(stop_s)
	);

	// Repeatable xorshift source
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Expected {prescaler wrap, underflow, prescaler, counter} after k steps
	function automatic logic [16:0] sim(input logic [6:0] p,
		input logic [7:0] c, input logic [2:0] sel, input int k);
		logic pw;
		logic uw;
		pw = 1'b0;
		uw = 1'b0;
		for (int i = 0; i < k; i++) begin
			if ((p & 7'((8'h01 << sel) - 8'h01)) == 7'h00) begin
				uw |= (c == 8'h00);
				c = c - 8'h01;
			end
			pw |= (p == 7'h00);
			p = (p == 7'h00) ? 7'h7f : p - 7'h01;
		end
		return {pw, uw, p, c};
	endfunction

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Hang guard, well past the longest expected run
	initial begin
		#3000000;
		errors++;
		final_report();
	end

	initial begin
		logic [7:0] q;
		logic [7:0] c;
		logic [7:0] p;
		logic [2:0] sel;
		logic [1:0] m;
		logic ie;
		logic w;
		logic x;
		logic [16:0] e;
		int k;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		// Reset values, last place unmapped
		for (int i = 0; i < 6; i++) begin
			cpu_u.rd(8'hd2 + 8'(i), q);
			chk(q, rst_tab[i]);
		end
		$display("test reset done");
		// Stopped prescaler ignores writes, counter holds
		cpu_u.wr(P8T_ADDR_PRESC, 8'h15);
		cpu_u.hold(40, 1'b0, 1'b0);
		cpu_u.rd(P8T_ADDR_PRESC, q);
		chk(q, 8'h7f);
		cpu_u.rd(P8T_ADDR_CNT, q);
		chk(q, 8'hff);
		$display("test hold done");
		// On-the-fly writes; twelve edges give exactly one step
		cpu_u.ctrl(1'b0, 1'b0, 1'b1, 3'h0);
		for (int i = 0; i < 5; i++) begin
			p = (i == 0) ? 8'hff : 8'(rnd());
			c = (i == 0) ? 8'h00 : 8'(rnd());
			cpu_u.wr(P8T_ADDR_PRESC, p);
			cpu_u.hold(11, 1'b0, 1'b0);
			cpu_u.rd(P8T_ADDR_PRESC, q);
			e = sim(p[6:0], 8'h01, 3'h0, 1);
			chk(q, {1'b0, e[14:8]});
			cpu_u.wr(P8T_ADDR_CNT, c);
			cpu_u.hold(11, 1'b0, 1'b0);
			cpu_u.rd(P8T_ADDR_CNT, q);
			chk(q, c - 8'h01);
		end
		$display("test live write done");
		// Software ways of setting and clearing the flag
		cpu_u.ctrl(1'b1, 1'b0, 1'b0, 3'h0);
		cpu_u.hold(20, 1'b0, 1'b0);
		cpu_u.rd(P8T_ADDR_CTRL, q);
		chk(q, 8'ha0);
		cpu_u.ctrl(1'b0, 1'b0, 1'b0, 3'h0);
		cpu_u.rd(P8T_ADDR_CTRL, q);
		chk(q, 8'h20);
		cpu_u.wr(P8T_ADDR_CNT, 8'h00);
		cpu_u.wr(8'hd7, 8'h55);
		cpu_u.rd(P8T_ADDR_CTRL, q);
		chk(q, 8'ha0);
		cpu_u.rd(8'hd7, q);
		chk(q, 8'h00);
		$display("test flag done");
		// Counter write landing on a step edge wins, no flag
		cpu_u.wr(P8T_ADDR_CNT, 8'h01);
		cpu_u.ctrl(1'b0, 1'b0, 1'b1, 3'h0);
		do @(negedge clk); while ((cyc + 2) % P8T_DIV_RATIO != 0);
		cpu_u.wr(P8T_ADDR_CNT, 8'h5a);
		cpu_u.rd(P8T_ADDR_CNT, q);
		chk(q, 8'h5a);
		cpu_u.rd(P8T_ADDR_CTRL, q);
		chk(q, 8'h28);
		$display("test collide done");
		// Every tap, random start, run k steps, then freeze by STOP
		for (int i = 0; i < 16; i++) begin
			sel = 3'(i);
			c = (i == 0) ? 8'h00 : 8'(rnd());
			k = 1 + int'(rnd() % 32'd150);
			q = 8'(rnd());
			ie = q[0];
			w = q[1];
			m = q[3:2];
			cpu_u.hold(1, w, 1'b0);
			cpu_u.ctrl(1'b0, ie, 1'b0, sel);
			cpu_u.wr(P8T_ADDR_CNT, c);
			cpu_u.ctrl(1'b0, ie, 1'b0, sel);
			cpu_u.wr(P8T_ADDR_EVT, 8'h03);
			cpu_u.wr(P8T_ADDR_MASK, {6'h00, m});
			cpu_u.ctrl(1'b0, ie, 1'b1, sel);
			cpu_u.hold(12 * k, w, 1'b1);
			e = sim(7'h7f, c, sel, k);
			x = (e[15] & ie) | (|(e[16:15] & m));
			cpu_u.rd(P8T_ADDR_CNT, q);
			chk(q, e[7:0]);
			cpu_u.rd(P8T_ADDR_PRESC, q);
			chk(q, {1'b0, e[14:8]});
			cpu_u.rd(P8T_ADDR_CTRL, q);
			chk(q, {e[15], ie, 2'b10, 1'b1, sel});
			cpu_u.rd(P8T_ADDR_EVT, q);
			chk(q, {6'h00, e[16:15]});
			chk({7'h00, irq}, {7'h00, x});
			chk({7'h00, wake}, {7'h00, x & w});
			cpu_u.wr(P8T_ADDR_CNT, 8'h5a);
			cpu_u.hold(30, w, 1'b1);
			cpu_u.rd(P8T_ADDR_CNT, q);
			chk(q, e[7:0]);
			$display("test tap %0d done", i);
		end
		final_report();
	end
endmodule
